// *** hw/afc_pkg.sv ***
// package for the filter configuration block: register map, field layout,
// reset values and output-rate periods in modulator ticks.
// assumes a modulator tick pulse supplied by the converter core.
package afc_pkg;

  // register map: eight per-setup filter configuration registers
  localparam logic [5:0]  FILT_CFG_BASE_ADDR = 6'h28;  // setup 0
  localparam logic [5:0]  FILT_CFG_LAST_ADDR = 6'h2F;  // setup 7
  localparam int          NUM_SETUPS         = 8;
  localparam logic [15:0] FILT_CFG_RESET     = 16'h0500;
  localparam logic [15:0] FILT_CFG_WR_MASK   = 16'h8F7F;  // bits 14:12 and 7 read zero

  // field positions
  localparam int DIRECT_DEC_BIT  = 15;
  localparam int DEC_MSB         = 14;
  localparam int PF_ENABLE_BIT   = 11;
  localparam int PF_SELECT_MSB   = 10;
  localparam int PF_SELECT_LSB   = 8;
  localparam int ORDER_MSB       = 6;
  localparam int ORDER_LSB       = 5;
  localparam int RATE_MSB        = 4;

  // field codes
  localparam logic [1:0] ORDER_SINC5_SINC1 = 2'h0;
  localparam logic [1:0] ORDER_SINC3       = 2'h3;
  localparam logic [2:0] PF_27SPS          = 3'h2;
  localparam logic [2:0] PF_21SPS          = 3'h3;
  localparam logic [2:0] PF_20SPS          = 3'h5;
  localparam logic [2:0] PF_16SPS          = 3'h6;
  localparam logic [4:0] RATE_CODE_SLOWEST = 5'h15;

  // modulator frequency; plain default, set to the converter's modulator clock
  localparam longint MOD_FREQ_HZ   = 64'd2000000;
  localparam int     DIRECT_FACTOR = 32;  // direct decimation: modulator_frequency / (32 * n)
  localparam int     PERIOD_W      = 24;

  // postfilter settling times in microseconds
  localparam logic [15:0] PF_SETTLE_27_US = 16'd36700;
  localparam logic [15:0] PF_SETTLE_21_US = 16'd40000;
  localparam logic [15:0] PF_SETTLE_20_US = 16'd50000;
  localparam logic [15:0] PF_SETTLE_16_US = 16'd60000;

  // modulator ticks per result for a rate given in hundredths of a sample per second
  function automatic logic [PERIOD_W-1:0] ticks_for_centi_sps(input longint centi_sps);
    longint t;
    t = (MOD_FREQ_HZ * 64'd100) / centi_sps;
    return t[PERIOD_W-1:0];
  endfunction : ticks_for_centi_sps

  // output rate of the sinc5 + sinc1 path per rate code, in centi sps
  function automatic longint rate_centi_sps(input logic [4:0] code);
    longint r;
    r = 64'd250;
    unique case (code)
      5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05: r = 64'd3125000;
      5'h06: r = 64'd1562500;
      5'h07: r = 64'd1041700;
      5'h08: r = 64'd520800;
      5'h09: r = 64'd259700;
      5'h0A: r = 64'd100700;
      5'h0B: r = 64'd50380;
      5'h0C: r = 64'd38100;
      5'h0D: r = 64'd20030;
      5'h0E: r = 64'd10020;
      5'h0F: r = 64'd5952;
      5'h10: r = 64'd4968;
      5'h11: r = 64'd2001;
      5'h12: r = 64'd1663;
      5'h13: r = 64'd1000;
      5'h14: r = 64'd500;
      default: r = 64'd250;  // slowest code and above
    endcase
    return r;
  endfunction : rate_centi_sps

endpackage : afc_pkg

// *** hw/afc_rate_timer.sv ***
// result-rate timer: counts modulator ticks and pulses once per result period.
// assumes a one-cycle tick pulse per modulator sample and a period of at least 1.
`timescale 1ns/1ps
module afc_rate_timer
(
  input  wire logic                          clk_in,        // system clock
  input  wire logic                          rst_in,        // sync reset, active high
  input  wire logic                          restart_in,    // abort and restart the count
  input  wire logic                          tick_in,       // modulator tick pulse
  input  wire logic [afc_pkg::PERIOD_W-1:0]  period_in,     // ticks per result
  output logic                               ready_out      // one-cycle result pulse
);

  logic [afc_pkg::PERIOD_W-1:0] count_r;    // ticks seen in this period
  logic [afc_pkg::PERIOD_W-1:0] count_nxt;
  logic                         ready_r;    // registered result pulse
  logic                         ready_nxt;

  // next count: restart wins, a full period wraps and fires
  always_comb
  begin
    count_nxt = count_r;
    ready_nxt = 1'b0;
    if (restart_in)
    begin
      // aborted conversion: begin from zero
      count_nxt = '0;
    end
    else if (tick_in)
    begin
      // period reached, or shortened below the running count
      if ((count_r + 1'b1) >= period_in)
      begin
        count_nxt = '0;
        ready_nxt = 1'b1;
      end
      else
      begin
        count_nxt = count_r + 1'b1;
      end
    end
  end

  // register the timer state
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      count_r <= '0;
      ready_r <= 1'b0;
    end
    else
    begin
      count_r <= count_nxt;
      ready_r <= ready_nxt;
    end
  end

  assign ready_out = ready_r;

endmodule : afc_rate_timer

// *** hw/afc_filter_config.sv ***
// filter configuration registers for eight setups and the decode of the
// active setup into filter mode and result period.
// assumes the serial interface engine presents one-cycle register strobes
// with a 6-bit address and the sequencer names the setup in use.
//
// Summary of operation
// RULE1: writing a filter register restarts conversion sequence
// RULE2: bit 15 maps low bits to sinc3 decimation
// RULE3: direct mode rate is modulator_frequency over 32 times value
// RULE4: reserved bits 14:12 and 7 read zero
// RULE5: bit 11 postfilter acts only with order 00
// RULE6: postfilter 010 27 sps, 011 21.25 sps
// RULE7: postfilter 101 20 sps, 110 16.67 sps
// RULE8: order 00 sinc5 plus sinc1, 11 sinc3
// RULE9: rate code sets sinc5 plus sinc1 data rate
// RULE10: reset value reads 0x0500
// RULE11: setups 1 to 7 share layout, reset
// RULE12: host writes only listed postfilter, order codes
`timescale 1ns/1ps
module afc_filter_config
(
  input  wire logic        CLK_IN,                // modulator-domain clock
  input  wire logic        SYS_RST_IN,            // sync reset, active high
  input  wire logic        REG_WR_IN,             // register write strobe
  input  wire logic        REG_RD_IN,             // register read strobe
  input  wire logic [5:0]  REG_ADDR_IN,           // register address
  input  wire logic [15:0] REG_WDATA_IN,          // write data
  input  wire logic [2:0]  SETUP_SEL_IN,          // setup used by the channel in progress
  input  wire logic        MOD_TICK_IN,           // one pulse per modulator sample
  output logic      [15:0] REG_RDATA_OUT,         // read data, valid after REG_RD_IN
  output logic             REG_RVALID_OUT,        // read data valid pulse
  output logic             CONV_RESTART_OUT,      // abort and restart at first channel
  output logic             DIRECT_DEC_OUT,        // direct sinc3 decimation active
  output logic             SINC3_SEL_OUT,         // sinc3 filter selected
  output logic             POSTFILTER_ON_OUT,     // postfilter in use
  output logic      [15:0] PF_SETTLE_US_OUT,      // postfilter settling, microseconds
  output logic      [23:0] PERIOD_TICKS_OUT,      // modulator ticks per result
  output logic             RESULT_READY_OUT       // one pulse per result
);

  // register storage, one word per setup
  logic [15:0] filt_cfg_r   [afc_pkg::NUM_SETUPS];
  logic [15:0] filt_cfg_nxt [afc_pkg::NUM_SETUPS];

  // read port and restart pulse
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic        rvalid_r;
  logic        rvalid_nxt;
  logic        restart_r;
  logic        restart_nxt;

  // decoded view of the active setup
  logic        direct_r;
  logic        direct_nxt;
  logic        sinc3_r;
  logic        sinc3_nxt;
  logic        pf_on_r;
  logic        pf_on_nxt;
  logic [15:0] settle_r;
  logic [15:0] settle_nxt;
  logic [23:0] period_r;
  logic [23:0] period_nxt;

  logic        addr_hit;      // address falls in the filter register range
  logic [2:0]  addr_idx;      // setup index of the address
  logic [15:0] active_cfg;    // register of the setup in use

  // address decode shared by read and write
  function automatic logic in_range(input logic [5:0] addr);
    return (addr >= afc_pkg::FILT_CFG_BASE_ADDR) && (addr <= afc_pkg::FILT_CFG_LAST_ADDR);
  endfunction : in_range

  assign addr_hit   = in_range(REG_ADDR_IN);
  assign addr_idx   = 3'(REG_ADDR_IN - afc_pkg::FILT_CFG_BASE_ADDR);  // RULE11
  assign active_cfg = filt_cfg_r[SETUP_SEL_IN];

  // register file next values and bus answers
  always_comb
  begin
    for (int i = 0; i < afc_pkg::NUM_SETUPS; i++)
    begin
      filt_cfg_nxt[i] = filt_cfg_r[i];
    end
    restart_nxt = 1'b0;
    rvalid_nxt  = REG_RD_IN;
    rdata_nxt   = rdata_r;
    if (REG_WR_IN && addr_hit)
    begin
      // reserved bits are stored as zero whatever the host writes
      filt_cfg_nxt[addr_idx] = REG_WDATA_IN & afc_pkg::FILT_CFG_WR_MASK;  // RULE4
      restart_nxt            = 1'b1;                                      // RULE1
    end
    if (REG_RD_IN)
    begin
      // unmapped addresses read as zero
      rdata_nxt = addr_hit ? filt_cfg_r[addr_idx] : 16'h0000;
    end
  end

  // register file flops
  always_ff @(posedge CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      for (int i = 0; i < afc_pkg::NUM_SETUPS; i++)
      begin
        filt_cfg_r[i] <= afc_pkg::FILT_CFG_RESET;  // RULE10 RULE11
      end
      rdata_r   <= 16'h0000;
      rvalid_r  <= 1'b0;
      restart_r <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < afc_pkg::NUM_SETUPS; i++)
      begin
        filt_cfg_r[i] <= filt_cfg_nxt[i];
      end
      rdata_r   <= rdata_nxt;
      rvalid_r  <= rvalid_nxt;
      restart_r <= restart_nxt;
    end
  end

  // decode of the active setup: direct mapping first, then postfilter,
  // then the plain order and rate fields
  always_comb
  begin
    direct_nxt = 1'b0;
    sinc3_nxt  = 1'b0;
    pf_on_nxt  = 1'b0;
    settle_nxt = 16'h0000;
    period_nxt = afc_pkg::ticks_for_centi_sps(afc_pkg::rate_centi_sps(
                   active_cfg[afc_pkg::RATE_MSB:0]));                      // RULE9
    if (active_cfg[afc_pkg::DIRECT_DEC_BIT])
    begin
      // all other options ignored; zero value treated as one to keep counting
      direct_nxt = 1'b1;                                                   // RULE2
      sinc3_nxt  = 1'b1;
      period_nxt = 24'(afc_pkg::DIRECT_FACTOR) *
                   24'((active_cfg[afc_pkg::DEC_MSB:0] == 15'h0000) ?
                       15'h0001 : active_cfg[afc_pkg::DEC_MSB:0]);         // RULE3
    end
    else
    begin
      // order field: only code 11 gives sinc3
      sinc3_nxt = (active_cfg[afc_pkg::ORDER_MSB:afc_pkg::ORDER_LSB] ==
                   afc_pkg::ORDER_SINC3);                                  // RULE8
      if (active_cfg[afc_pkg::PF_ENABLE_BIT] &&
          (active_cfg[afc_pkg::ORDER_MSB:afc_pkg::ORDER_LSB] ==
           afc_pkg::ORDER_SINC5_SINC1))                                    // RULE5
      begin
        pf_on_nxt = 1'b1;
        unique case (active_cfg[afc_pkg::PF_SELECT_MSB:afc_pkg::PF_SELECT_LSB])
          afc_pkg::PF_27SPS:
          begin
            period_nxt = afc_pkg::ticks_for_centi_sps(64'd2700);           // RULE6
            settle_nxt = afc_pkg::PF_SETTLE_27_US;
          end
          afc_pkg::PF_21SPS:
          begin
            period_nxt = afc_pkg::ticks_for_centi_sps(64'd2125);           // RULE6
            settle_nxt = afc_pkg::PF_SETTLE_21_US;
          end
          afc_pkg::PF_20SPS:
          begin
            period_nxt = afc_pkg::ticks_for_centi_sps(64'd2000);           // RULE7
            settle_nxt = afc_pkg::PF_SETTLE_20_US;
          end
          afc_pkg::PF_16SPS:
          begin
            period_nxt = afc_pkg::ticks_for_centi_sps(64'd1667);           // RULE7
            settle_nxt = afc_pkg::PF_SETTLE_16_US;
          end
          default:
          begin
            // unlisted code: postfilter stays off, plain rate used
            pf_on_nxt = 1'b0;
          end
        endcase
      end
    end
  end

  // decode flops
  always_ff @(posedge CLK_IN)
  begin
    if (SYS_RST_IN)
    begin
      direct_r <= 1'b0;
      sinc3_r  <= 1'b0;
      pf_on_r  <= 1'b0;
      settle_r <= 16'h0000;
      period_r <= 24'h000001;
    end
    else
    begin
      direct_r <= direct_nxt;
      sinc3_r  <= sinc3_nxt;
      pf_on_r  <= pf_on_nxt;
      settle_r <= settle_nxt;
      period_r <= period_nxt;
    end
  end

  // result timer, restarted by any filter register write
  afc_rate_timer u_rate_timer
  (
    .clk_in     (CLK_IN),
    .rst_in     (SYS_RST_IN),
    .restart_in (restart_r),      // RULE1
    .tick_in    (MOD_TICK_IN),
    .period_in  (period_r),
    .ready_out  (RESULT_READY_OUT)
  );

  assign REG_RDATA_OUT     = rdata_r;
  assign REG_RVALID_OUT    = rvalid_r;
  assign CONV_RESTART_OUT  = restart_r;
  assign DIRECT_DEC_OUT    = direct_r;
  assign SINC3_SEL_OUT     = sinc3_r;
  assign POSTFILTER_ON_OUT = pf_on_r;
  assign PF_SETTLE_US_OUT  = settle_r;
  assign PERIOD_TICKS_OUT  = period_r;

endmodule : afc_filter_config

// *** test/afc_filter_config_asserts.sv ***
// checker: port timing of the filter configuration block
// assumes it is bound onto afc_filter_config
`timescale 1ns/1ps
module afc_filter_config_asserts
(
  input wire logic        CLK_IN,
  input wire logic        SYS_RST_IN,
  input wire logic        REG_WR_IN,
  input wire logic        REG_RD_IN,
  input wire logic [5:0]  REG_ADDR_IN,
  input wire logic [15:0] REG_WDATA_IN,
  input wire logic [2:0]  SETUP_SEL_IN,
  input wire logic        MOD_TICK_IN,
  input wire logic [15:0] REG_RDATA_OUT,
  input wire logic        REG_RVALID_OUT,
  input wire logic        CONV_RESTART_OUT,
  input wire logic        DIRECT_DEC_OUT,
  input wire logic        SINC3_SEL_OUT,
  input wire logic        POSTFILTER_ON_OUT,
  input wire logic [15:0] PF_SETTLE_US_OUT,
  input wire logic [23:0] PERIOD_TICKS_OUT,
  input wire logic        RESULT_READY_OUT
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (SYS_RST_IN);
  wire logic        hit    = REG_ADDR_IN[5:3] == 3'h5;  // one of the eight setups
  wire logic        wr_hit = REG_WR_IN && hit;          // filter write taken
  logic      [15:0] wd1_r, wd2_r;                      // write data one, two cycles back
  wire logic [14:0] dec = wd2_r[14:0] & 15'h0F7F;      // stored decimation value
  // delay line for the write data
  always_ff @(posedge CLK_IN)
  begin
    wd1_r <= REG_WDATA_IN;
    wd2_r <= wd1_r;
  end
  // write to the setup in use, then a quiet cycle with the setup held
  sequence own_wr_s;
    REG_WR_IN && REG_ADDR_IN == {3'h5, SETUP_SEL_IN} ##1
    !REG_WR_IN && $stable(SETUP_SEL_IN) ##1 $stable(SETUP_SEL_IN);
  endsequence
  write_restart_a: assert property (wr_hit |=> CONV_RESTART_OUT)
    else $error("no restart after write");
  no_spur_a: assert property (CONV_RESTART_OUT |-> $past(wr_hit))
    else $error("restart without write");
  direct_map_a: assert property (own_wr_s ##0 wd2_r[15] |-> DIRECT_DEC_OUT
    && SINC3_SEL_OUT && !POSTFILTER_ON_OUT
    && PERIOD_TICKS_OUT == 24'h20 * (dec == 15'h0 ? 15'h1 : dec))
    else $error("direct decimation wrong");
  postfilter_on_a: assert property (own_wr_s |-> POSTFILTER_ON_OUT == (!wd2_r[15]
    && wd2_r[11] && wd2_r[6:5] == 2'h0 && wd2_r[10:8] inside {3'h2, 3'h3, 3'h5, 3'h6}))
    else $error("postfilter enable wrong");
  sinc3_order_a: assert property (own_wr_s |-> SINC3_SEL_OUT == (wd2_r[15]
    || wd2_r[6:5] == 2'h3)) else $error("sinc3 select wrong");
  settle_time_a: assert property (own_wr_s ##0 POSTFILTER_ON_OUT |->
    PF_SETTLE_US_OUT == (wd2_r[10] ? (wd2_r[8] ? 16'hC350 : 16'hEA60)
    : (wd2_r[8] ? 16'h9C40 : 16'h8F5C))) else $error("settling wrong");
  read_miss_a: assert property (REG_RD_IN && !hit |=> REG_RVALID_OUT
    && REG_RDATA_OUT == 16'h0) else $error("unmapped read not zero");
  reserved_zero_a: assert property (REG_RVALID_OUT |-> !(|(REG_RDATA_OUT & 16'h7080)))
    else $error("reserved bits set");
  result_tick_a: assert property (RESULT_READY_OUT |-> $past(MOD_TICK_IN))
    else $error("result without tick");
endmodule : afc_filter_config_asserts

// *** test/afc_host_model.sv ***
// host model: one-cycle register strobes as the serial engine gives them
// assumes tasks are called from one process, right after a clock edge
`timescale 1ns/1ps
module afc_host_model
(
  input  wire logic        clk_in,    // system clock
  output logic             wr_out,    // write strobe
  output logic             rd_out,    // read strobe
  output logic      [5:0]  addr_out,  // register address
  output logic      [15:0] wdata_out  // write data
);
  // idle bus at time zero
  initial
  begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    addr_out = 6'h0;
    wdata_out = 16'h0;
  end
  // one access, then the lines stop holding the old value
  task automatic access(input logic w, input logic [5:0] a, input logic [15:0] d);
    @(posedge clk_in);
    wr_out <= w;
    rd_out <= !w;
    addr_out <= a;
    wdata_out <= d;
    @(posedge clk_in);
    wr_out <= 1'b0;
    rd_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask : access
endmodule : afc_host_model

// *** test/afc_filter_config_bench.sv ***
// bench: register access, decode and result rate of the filter block
// assumes afc_pkg, the design and the checker are compiled first
`timescale 1ns/1ps
module afc_filter_config_bench;
  logic        clk, rst, tick, ten, wr, rd;     // clock, reset, tick, strobes
  logic [2:0]  sel;                             // setup in use
  logic [5:0]  addr, a;                         // bus and scratch address
  logic [15:0] wdata, d, rdata, settle;         // data
  logic        rvalid, restart, direct, sinc3, pfon, ready;
  logic [23:0] period;                          // ticks per result
  logic [31:0] seed = 32'h60120A5B;             // xorshift state
  int          failures = 0, checked = 0, ntick = 0, gap = 0, nres = 0;
  logic [15:0] q[$];                            // expected read data
  logic [2:0]  pf_tab[4] = '{3'h2, 3'h3, 3'h5, 3'h6};
  logic [15:0] st_tab[4] = '{16'h8F5C, 16'h9C40, 16'hC350, 16'hEA60};
  int          cps_tab[4] = '{2700, 2125, 2000, 1667};
  afc_host_model u_host (.clk_in(clk), .wr_out(wr), .rd_out(rd), .addr_out(addr),
    .wdata_out(wdata));
  afc_filter_config u_afc_filter_config (.CLK_IN(clk), .SYS_RST_IN(rst), .REG_WR_IN(wr),
    .REG_RD_IN(rd), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .SETUP_SEL_IN(sel),
    .MOD_TICK_IN(tick), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid),
    .CONV_RESTART_OUT(restart), .DIRECT_DEC_OUT(direct), .SINC3_SEL_OUT(sinc3),
    .POSTFILTER_ON_OUT(pfon), .PF_SETTLE_US_OUT(settle), .PERIOD_TICKS_OUT(period),
    .RESULT_READY_OUT(ready));
  always #2.5 clk = ~clk;
  // modulator ticks on every other cycle once enabled
  always @(posedge clk) tick <= ten & ~tick;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // read answers against the queue; ticks counted between results
  always @(posedge clk)
  begin
    if (rvalid === 1'b1)
      chk({8'h0, rdata}, {8'h0, q.pop_front()});
    if (restart === 1'b1)
      ntick = 0;
    else if (ready === 1'b1)
    begin
      gap = ntick;
      nres++;
      ntick = int'(tick);
    end
    else
      ntick += int'(tick);
  end
  task automatic rdx(input logic [5:0] ra, input logic [15:0] e);
    q.push_back(e);
    u_host.access(1'b0, ra, 16'h0);
  endtask : rdx
  // write setup 0 and let the decode settle
  task automatic wcfg(input logic [15:0] v);
    u_host.access(1'b1, 6'h28, v);
    @(posedge clk);
    #1;
  endtask : wcfg
  task automatic wait_res(input int n);
    int goal;
    goal = nres + n;
    for (int k = 0; k < 1000 && nres < goal; k++)
      @(posedge clk);
    #1;
    if (nres < goal)
    begin
      failures++;
      complete_run();
    end
  endtask : wait_res
  task automatic complete_run();
    if (q.size() != 0)
      failures++;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    tick = 1'b0;
    ten = 1'b0;
    sel = 3'h0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++)
      rdx(6'h28 + 6'(i), 16'h0500);
    rdx(6'h27, 16'h0000);
    rdx(6'h30, 16'h0000);
    $display("reset values done");
    for (int i = 0; i < 24; i++)
    begin
      seed = xs(seed);
      sel <= seed[30:28];
      a = {3'h5, seed[26:24]};
      d = (seed[15:0] & 16'h881F) | {5'h0, pf_tab[seed[17:16]], 8'h00};
      d[6:5] = {2{seed[18]}};
      u_host.access(1'b1, a, d);
      rdx(a, d);
    end
    u_host.access(1'b1, 6'h2F, 16'h7580);
    rdx(6'h2F, 16'h0500);
    u_host.access(1'b1, 6'h30, 16'h1234);
    rdx(6'h30, 16'h0000);
    sel <= 3'h0;
    $display("register access done");
    for (int i = 0; i < 4; i++)
    begin
      wcfg({5'h01, pf_tab[i], 8'h00});
      chk(pfon, 24'h1);
      chk(settle, st_tab[i]);
      chk(period, 24'(afc_pkg::MOD_FREQ_HZ * 100 / cps_tab[i]));
    end
    wcfg(16'h0D60);
    chk(pfon, 24'h0);
    chk(settle, 24'h0);
    chk(sinc3, 24'h1);
    wcfg(16'h0500);
    chk(sinc3, 24'h0);
    chk(period, 24'(afc_pkg::MOD_FREQ_HZ / 31250));
    wcfg(16'h0515);
    chk(period, 24'(afc_pkg::MOD_FREQ_HZ * 2 / 5));
    $display("decode done");
    // a zero decimation value is counted as one
    wcfg(16'h8000);
    chk(direct, 24'h1);
    chk(period, 24'h20);
    wcfg(16'h8003);
    chk(direct, 24'h1);
    chk(period, 24'h60);
    ten <= 1'b1;
    wait_res(2);
    chk(24'(gap), 24'h60);
    repeat (40) @(posedge clk);
    wcfg(16'h8003);
    wait_res(1);
    chk(24'(gap), 24'h60);
    $display("result rate done");
    repeat (3) @(posedge clk);
    complete_run();
  end
endmodule : afc_filter_config_bench
bind afc_filter_config afc_filter_config_asserts u_chk (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN),
  .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN), .REG_ADDR_IN(REG_ADDR_IN),
  .REG_WDATA_IN(REG_WDATA_IN), .SETUP_SEL_IN(SETUP_SEL_IN), .MOD_TICK_IN(MOD_TICK_IN),
  .REG_RDATA_OUT(REG_RDATA_OUT), .REG_RVALID_OUT(REG_RVALID_OUT),
  .CONV_RESTART_OUT(CONV_RESTART_OUT), .DIRECT_DEC_OUT(DIRECT_DEC_OUT),
  .SINC3_SEL_OUT(SINC3_SEL_OUT), .POSTFILTER_ON_OUT(POSTFILTER_ON_OUT),
  .PF_SETTLE_US_OUT(PF_SETTLE_US_OUT), .PERIOD_TICKS_OUT(PERIOD_TICKS_OUT),
  .RESULT_READY_OUT(RESULT_READY_OUT));
